// >>> timer_irq_pkg.sv
// Shared constants for the timer interrupt and channel A/B pin control block
package timer_irq_pkg;

    // ************************************************************
    // Register map, byte addresses of aligned 32-bit words
    // ************************************************************
    localparam int         ADDR_W         = 6;
    localparam logic [5:0] OFS_IRQ_EN     = 6'h00;
    localparam logic [5:0] OFS_STATUS     = 6'h04;
    localparam logic [5:0] OFS_IO_CTL     = 6'h08;
    localparam logic [5:0] OFS_COUNTER    = 6'h0c;
    localparam logic [5:0] OFS_GR_BASE    = 6'h10;
    localparam logic [5:0] OFS_RUN        = 6'h20;
    localparam int         GR_STRIDE      = 4;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int         NUM_CH         = 4;
    localparam int         NUM_IO_CH      = 2;
    localparam int         NUM_FLAGS      = 5;
    localparam int         WRAP_IDX       = 4;
    localparam int         BIT_WRAP       = 7;
    localparam int         IO_CH_STRIDE   = 4;
    localparam int         BIT_FUNC_SEL   = 2;
    localparam int         BIT_ACTION_HI  = 1;
    localparam int         BIT_RUN        = 0;
    localparam logic [7:0] IE_RSV_MASK    = 8'h70;
    localparam logic [7:0] STAT_RSV_MASK  = 8'h70;
    localparam logic [7:0] IOC_RSV_MASK   = 8'h88;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0]  IE_RESET      = 8'h00;
    localparam logic [7:0]  IOC_RESET     = 8'h00;
    localparam logic [15:0] CNT_RESET     = 16'h0000;
    localparam logic [15:0] GR_RESET      = 16'hffff;

    // ************************************************************
    // Pin action and capture edge codes
    // ************************************************************
    localparam logic [1:0] ACT_NONE       = 2'b00;
    localparam logic [1:0] ACT_LOW        = 2'b01;
    localparam logic [1:0] ACT_HIGH       = 2'b10;
    localparam logic [1:0] ACT_TOGGLE     = 2'b11;
    localparam logic [1:0] EDGE_RISE      = 2'b00;
    localparam logic [1:0] EDGE_FALL      = 2'b01;

endpackage

// >>> event_flag.sv
// Sticky event flag cleared by read-as-one then write-zero
`timescale 1ns/1ps
module event_flag (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic nrst_i,
    // Event and software access
    input  wire logic set_i,
    input  wire logic arm_i,
    input  wire logic wr_i,
    input  wire logic wbit_i,
    // Flag state
    output logic      flag_o
);

    typedef struct packed {
        logic flag;
        logic armed;
    } flag_state_t;

    flag_state_t s_reg;
    flag_state_t s_next;

    always_comb
    begin
        s_next = s_reg;
        if (arm_i)
        begin
            s_next.armed = 1'b1;
        end
        if (wr_i)
        begin
            // Only a zero after a read that saw one clears
            if (s_reg.armed && !wbit_i)
            begin
                s_next.flag = 1'b0;
            end
            s_next.armed = 1'b0;
        end
        // Set beats a clear in the same cycle
        if (set_i)
        begin
            s_next.flag = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign flag_o = s_reg.flag;

endmodule

// >>> chan_io.sv
// One channel pin: compare output action and capture edge detection
`timescale 1ns/1ps
module chan_io
    import timer_irq_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    // Pin and control
    input  wire logic       pin_i,
    input  wire logic       func_sel_i,
    input  wire logic [1:0] action_i,
    input  wire logic       match_i,
    // Results
    output logic            pin_o,
    output logic            capture_o
);

    typedef struct packed {
        logic primed;
        logic prev;
        logic level;
    } io_state_t;

    io_state_t s_reg;
    io_state_t s_next;
    logic      rise;
    logic      fall;

    // No edge is seen before the first sample after reset
    assign rise = s_reg.primed & pin_i & ~s_reg.prev;
    assign fall = s_reg.primed & ~pin_i & s_reg.prev;

    always_comb
    begin
        s_next        = s_reg;
        s_next.primed = 1'b1;
        s_next.prev   = pin_i;
        capture_o     = 1'b0;
        if (func_sel_i)
        begin
            if (action_i[BIT_ACTION_HI])
            begin
                capture_o = rise | fall;
            end
            else if (action_i == EDGE_FALL)
            begin
                capture_o = fall;
            end
            else
            begin
                capture_o = rise;
            end
        end
        else if (match_i)
        begin
            case (action_i)
                ACT_LOW:    s_next.level = 1'b0;
                ACT_HIGH:   s_next.level = 1'b1;
                ACT_TOGGLE: s_next.level = ~s_reg.level;
                default:    s_next.level = s_reg.level;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign pin_o = s_reg.level;

endmodule

// >>> timer_irq_and_ab_io_control.sv
// Timer counter, general registers, event flags, interrupt gating and A/B pin control
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps

module timer_irq_and_ab_io_control
    import timer_irq_pkg::*;
#(
    parameter int CNT_W = 16
)(
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              nrst_i,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic [31:0]            avs_readdata_o,
    output logic                   avs_waitrequest_o,
    // Channel pins
    input  wire logic              chan_a_pin_i,
    output logic                   chan_a_pin_o,
    output logic                   chan_a_pin_oe_n_o,
    input  wire logic              chan_b_pin_i,
    output logic                   chan_b_pin_o,
    output logic                   chan_b_pin_oe_n_o,
    // Interrupt requests
    output logic                   wrap_irq_o,
    output logic                   chan_a_irq_o,
    output logic                   chan_b_irq_o,
    output logic                   chan_c_irq_o,
    output logic                   chan_d_irq_o
);

    // ************************************************************
    // Parameter check
    // ************************************************************
    generate
        if (CNT_W < 2 || CNT_W > 16)
        begin : g_bad_width
            $error("CNT_W must lie between 2 and 16");
        end
    endgenerate

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic                         ack;
        logic [31:0]                  rdata;
        logic [7:0]                   irq_en;
        logic [7:0]                   io_ctl;
        logic                         run;
        logic [CNT_W-1:0]             cnt;
        logic                         moved;
        logic [NUM_CH-1:0][CNT_W-1:0] gr;
    } state_t;

    state_t                 s_reg;
    state_t                 s_next;

    logic                   req;
    logic                   take;
    logic                   wr_take;
    logic                   stat_rd;
    logic                   stat_wr;
    logic                   cnt_wr;
    logic                   wrap;
    logic [NUM_CH-1:0]      cap_mode;
    logic [NUM_CH-1:0]      match;
    logic [NUM_CH-1:0]      capture;
    logic [NUM_FLAGS-1:0]   flag_set;
    logic [NUM_FLAGS-1:0]   flags;
    logic [7:0]             status_val;
    logic [NUM_IO_CH-1:0]   pin_in;
    logic [NUM_IO_CH-1:0]   pin_out;

    // Byte-lane merge for writes honouring byteenable
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_val,
        input logic [31:0] wdata,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                res[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ************************************************************
    // Bus handshake
    // ************************************************************
    // Every access waits exactly one cycle; this keeps read data registered
    assign req               = avs_read_i | avs_write_i;
    assign take              = req & s_reg.ack;
    assign wr_take           = take & avs_write_i;
    assign avs_waitrequest_o = req & ~s_reg.ack;
    assign avs_readdata_o    = s_reg.rdata;

    assign stat_rd = take & avs_read_i & (avs_address_i == OFS_STATUS);
    assign stat_wr = wr_take & (avs_address_i == OFS_STATUS) & avs_byteenable_i[0];
    assign cnt_wr  = wr_take & (avs_address_i == OFS_COUNTER);

    // ************************************************************
    // Counter events
    // ************************************************************
    assign wrap = s_reg.run & ~cnt_wr & (&s_reg.cnt);

    assign cap_mode[0] = s_reg.io_ctl[BIT_FUNC_SEL];
    assign cap_mode[1] = s_reg.io_ctl[IO_CH_STRIDE + BIT_FUNC_SEL];
    assign cap_mode[2] = 1'b0;
    assign cap_mode[3] = 1'b0;

    assign capture[NUM_CH-1:NUM_IO_CH] = '0;
    assign pin_in = {chan_b_pin_i, chan_a_pin_i};

    genvar k;
    generate
        for (k = 0; k < NUM_CH; k++)
        begin : g_match
            // Match fires once per counted value, not while the counter is stopped
            assign match[k]    = ~cap_mode[k] & s_reg.moved & (s_reg.cnt == s_reg.gr[k]);
            assign flag_set[k] = match[k] | capture[k];
        end
        for (k = 0; k < NUM_IO_CH; k++)
        begin : g_io
            chan_io u_chan_io (
                .clock_i    (clock_i),
                .nrst_i     (nrst_i),
                .pin_i      (pin_in[k]),
                .func_sel_i (cap_mode[k]),
                .action_i   (s_reg.io_ctl[k*IO_CH_STRIDE +: 2]),
                .match_i    (match[k]),
                .pin_o      (pin_out[k]),
                .capture_o  (capture[k])
            );
        end
    endgenerate

    assign flag_set[WRAP_IDX] = wrap;

    // ************************************************************
    // Event flags
    // ************************************************************
    generate
        for (k = 0; k < NUM_FLAGS; k++)
        begin : g_flag
            localparam int B = (k == WRAP_IDX) ? BIT_WRAP : k;
            // Arm from the value software actually received
            event_flag u_flag (
                .clock_i (clock_i),
                .nrst_i  (nrst_i),
                .set_i   (flag_set[k]),
                .arm_i   (stat_rd & s_reg.rdata[B]),
                .wr_i    (stat_wr),
                .wbit_i  (avs_writedata_i[B]),
                .flag_o  (flags[k])
            );
        end
    endgenerate

    assign status_val = {flags[WRAP_IDX], 3'b000, flags[NUM_CH-1:0]} | STAT_RSV_MASK;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        logic [31:0] merged;
        merged = lane_merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i);
        s_next = s_reg;
        s_next.ack = req & ~s_reg.ack;

        // Read data are sampled during the wait cycle
        if (avs_read_i && !s_reg.ack)
        begin
            case (avs_address_i)
                OFS_IRQ_EN:  s_next.rdata = {24'h000000, s_reg.irq_en | IE_RSV_MASK};
                OFS_STATUS:  s_next.rdata = {24'h000000, status_val};
                OFS_IO_CTL:  s_next.rdata = {24'h000000, s_reg.io_ctl | IOC_RSV_MASK};
                OFS_COUNTER: s_next.rdata = 32'(s_reg.cnt);
                OFS_RUN:     s_next.rdata = 32'(s_reg.run);
                default:
                begin
                    s_next.rdata = 32'h0000_0000;
                    for (int g = 0; g < NUM_CH; g++)
                    begin
                        if (avs_address_i == OFS_GR_BASE + 6'(g * GR_STRIDE))
                        begin
                            s_next.rdata = 32'(s_reg.gr[g]);
                        end
                    end
                end
            endcase
        end

        // Register writes
        if (wr_take)
        begin
            case (avs_address_i)
                OFS_IRQ_EN:
                begin
                    merged = lane_merge(32'(s_reg.irq_en), avs_writedata_i, avs_byteenable_i);
                    s_next.irq_en = merged[7:0] & ~IE_RSV_MASK;
                end
                OFS_IO_CTL:
                begin
                    merged = lane_merge(32'(s_reg.io_ctl), avs_writedata_i, avs_byteenable_i);
                    s_next.io_ctl = merged[7:0] & ~IOC_RSV_MASK;
                end
                OFS_RUN:
                begin
                    if (avs_byteenable_i[0])
                    begin
                        s_next.run = avs_writedata_i[BIT_RUN];
                    end
                end
                default:
                begin
                    s_next.run = s_reg.run;
                end
            endcase
        end

        // Counter: software write wins over counting
        s_next.moved = s_reg.run & ~cnt_wr;
        if (cnt_wr)
        begin
            merged = lane_merge(32'(s_reg.cnt), avs_writedata_i, avs_byteenable_i);
            s_next.cnt = merged[CNT_W-1:0];
        end
        else if (s_reg.run)
        begin
            s_next.cnt = s_reg.cnt + CNT_W'(1);
        end

        // General registers: a capture beats a software write
        for (int g = 0; g < NUM_CH; g++)
        begin
            if (capture[g])
            begin
                s_next.gr[g] = s_reg.cnt;
            end
            else if (wr_take && avs_address_i == OFS_GR_BASE + 6'(g * GR_STRIDE))
            begin
                merged = lane_merge(32'(s_reg.gr[g]), avs_writedata_i, avs_byteenable_i);
                s_next.gr[g] = merged[CNT_W-1:0];
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_reg.ack    <= 1'b0;
            s_reg.rdata  <= 32'h0000_0000;
            s_reg.irq_en <= IE_RESET;
            s_reg.io_ctl <= IOC_RESET;
            s_reg.run    <= 1'b0;
            s_reg.cnt    <= CNT_RESET[CNT_W-1:0];
            s_reg.moved  <= 1'b0;
            s_reg.gr     <= {NUM_CH{GR_RESET[CNT_W-1:0]}};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign chan_a_pin_o      = pin_out[0];
    assign chan_b_pin_o      = pin_out[1];
    // Pin is driven only in compare mode
    assign chan_a_pin_oe_n_o = cap_mode[0];
    assign chan_b_pin_oe_n_o = cap_mode[1];

    assign wrap_irq_o   = flags[WRAP_IDX] & s_reg.irq_en[BIT_WRAP];
    assign chan_a_irq_o = flags[0] & s_reg.irq_en[0];
    assign chan_b_irq_o = flags[1] & s_reg.irq_en[1];
    assign chan_c_irq_o = flags[2] & s_reg.irq_en[2];
    assign chan_d_irq_o = flags[3] & s_reg.irq_en[3];

endmodule

// >>> timer_irq_and_ab_io_control_asserts.sv
// Port-level checks for the timer event and A/B pin block
`timescale 1ns/1ps
module timer_irq_and_ab_io_control_asserts
    import timer_irq_pkg::*;
#(
    parameter int CNT_W = 16
)(
    // Clock and reset
    input wire logic              clock_i,
    input wire logic              nrst_i,
    // Register bus
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic [31:0]       avs_writedata_i,
    input wire logic [3:0]        avs_byteenable_i,
    input wire logic [31:0]       avs_readdata_o,
    input wire logic              avs_waitrequest_o,
    // Pins and requests
    input wire logic              chan_a_pin_oe_n_o,
    input wire logic              chan_b_pin_oe_n_o,
    input wire logic              wrap_irq_o,
    input wire logic              chan_a_irq_o
);
    // ********
    // Sequences
    // ********
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence s_req_new;
        (avs_read_i || avs_write_i) && !$past(avs_read_i || avs_write_i);
    endsequence
    sequence s_take(logic [ADDR_W-1:0] a);
        avs_read_i && !avs_waitrequest_o && avs_address_i == a;
    endsequence
    sequence s_ctl_write;
        avs_write_i && !avs_waitrequest_o && avs_address_i == OFS_IO_CTL && avs_byteenable_i[0];
    endsequence
    // ********
    // Assertions
    // ********
    a_wait_one: assert property (s_req_new |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("bus wait state count wrong");
    a_wait_idle: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("wait raised without a request");
    a_enable_rsv: assert property (s_take(OFS_IRQ_EN) |-> avs_readdata_o[6:4] == 3'b111)
        else $error("enable reserved bits not one");
    a_status_rsv: assert property (s_take(OFS_STATUS) |-> avs_readdata_o[6:4] == 3'b111)
        else $error("status reserved bits not one");
    a_ctl_rsv: assert property (s_take(OFS_IO_CTL) |-> avs_readdata_o[7] && avs_readdata_o[3])
        else $error("control reserved bits not one");
    a_mode_a: assert property (s_ctl_write |=> chan_a_pin_oe_n_o == $past(avs_writedata_i[2]))
        else $error("channel a mode not applied");
    a_mode_b: assert property (s_ctl_write |=> chan_b_pin_oe_n_o == $past(avs_writedata_i[6]))
        else $error("channel b mode not applied");
    a_irq_hold: assert property ($fell(chan_a_irq_o) || $fell(wrap_irq_o) |-> $past(avs_write_i && !avs_waitrequest_o))
        else $error("request dropped without a write");
endmodule

bind timer_irq_and_ab_io_control timer_irq_and_ab_io_control_asserts #(.CNT_W(CNT_W)) timer_irq_and_ab_io_control_asserts_i (
    .clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .chan_a_pin_oe_n_o(chan_a_pin_oe_n_o), .chan_b_pin_oe_n_o(chan_b_pin_oe_n_o),
    .wrap_irq_o(wrap_irq_o), .chan_a_irq_o(chan_a_irq_o));

// >>> pin_partner.sv
// Far-side pin model: a capture source that yields the wire when the block drives
`timescale 1ns/1ps
module pin_partner (
    // Clock
    input  wire logic       clock_i,
    // Bench request
    input  wire logic       level_i,
    input  wire logic [3:0] delay_i,
    // Block side of the pin
    input  wire logic       dut_pin_i,
    input  wire logic       dut_oe_n_i,
    // Resolved wire
    output logic            wire_o
);
    logic       drive_reg = 1'b0;
    logic [3:0] wait_reg  = 4'h0;
    // A slow source keeps the old level for delay_i+1 cycles
    always_ff @(posedge clock_i)
    begin
        if (drive_reg == level_i)
            wait_reg <= 4'h0;
        else if (wait_reg >= delay_i)
            drive_reg <= level_i;
        else
            wait_reg <= wait_reg + 4'h1;
    end
    // The block owns the wire while its enable is low
    assign wire_o = dut_oe_n_i ? drive_reg : dut_pin_i;
endmodule

// >>> timer_irq_and_ab_io_control_tb.sv
// Self-checking bench for the timer event, interrupt and A/B pin block
`timescale 1ns/1ps
module timer_irq_and_ab_io_control_tb import timer_irq_pkg::*;;
    logic        clock_i     = 1'b0;
    logic        nrst_i      = 1'b0;
    logic [5:0]  addr        = 6'h00;
    logic        rd          = 1'b0;
    logic        wr          = 1'b0;
    logic [31:0] wdata       = 32'h0;
    logic [3:0]  be          = 4'hf;
    logic [1:0]  lvl         = 2'b00;
    logic [3:0]  dly         = 4'h0;
    logic [1:0]  pexp        = 2'b00;
    logic [31:0] rdata;
    logic [31:0] rq;
    logic        wreq;
    logic        wrap_irq;
    logic [1:0]  pin_o;
    logic [1:0]  oe_n;
    logic [1:0]  pin_w;
    logic [3:0]  irq;
    int          miscompares = 0;
    int          checked     = 0;

    timer_irq_and_ab_io_control #(.CNT_W(16)) timer_irq_and_ab_io_control_i (
        .clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
        .chan_a_pin_i(pin_w[0]), .chan_a_pin_o(pin_o[0]), .chan_a_pin_oe_n_o(oe_n[0]),
        .chan_b_pin_i(pin_w[1]), .chan_b_pin_o(pin_o[1]), .chan_b_pin_oe_n_o(oe_n[1]),
        .wrap_irq_o(wrap_irq), .chan_a_irq_o(irq[0]), .chan_b_irq_o(irq[1]),
        .chan_c_irq_o(irq[2]), .chan_d_irq_o(irq[3]));
    for (genvar k = 0; k < 2; k++)
    begin : g_pin
        pin_partner pin_partner_i (.clock_i(clock_i), .level_i(lvl[k]), .delay_i(dly),
            .dut_pin_i(pin_o[k]), .dut_oe_n_i(oe_n[k]), .wire_o(pin_w[k]));
    end

    initial
    begin
        forever #5 clock_i = ~clock_i;
    end

    // ********
    // Bus and compare helpers
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Holds the request until waitrequest is seen low at a rising edge
    // Only the watchdog ends a wait that never sees waitrequest low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge clock_i);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        be <= b;
        do
        begin
            @(posedge clock_i);
        end
        while (wreq !== 1'b0);
        rq = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wrr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(rq, e);
    endtask
    function automatic logic exp_pin(input logic prev, input logic [1:0] act);
        return act == ACT_NONE ? prev : act == ACT_TOGGLE ? !prev : act == ACT_HIGH;
    endfunction
    function automatic logic exp_cap(input logic [1:0] code, input logic rise);
        return code[1] || (code == EDGE_RISE && rise) || (code == EDGE_FALL && !rise);
    endfunction
    // Counter runs briefly from start, then status is read back into rq
    task automatic spin(input logic [15:0] start);
        wrr(OFS_RUN, 32'h0);
        wrr(OFS_COUNTER, {16'h0, start});
        wrr(OFS_RUN, 32'h1);
        repeat (8) @(posedge clock_i);
        wrr(OFS_RUN, 32'h0);
        bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
    endtask
    // A write of ones, then an unarmed zero write, must not clear; a read then a zero write must
    task automatic clr(input int i);
        wrr(OFS_STATUS, 32'hff);
        wrr(OFS_STATUS, 32'h0);
        bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
        chk(rq[i], 1'b1);
        wrr(OFS_STATUS, 32'h0);
        rdc(OFS_STATUS, 32'h70);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge clock_i);
        miscompares++;
        tally_and_finish();
    end

    // ********
    // Tests
    // ********
    initial
    begin
        int g;
        int ch;
        logic [1:0]  act;
        logic [31:0] r;
        void'($urandom(32'h5919aed1));
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        rdc(OFS_IRQ_EN, 32'h70);
        rdc(OFS_STATUS, 32'h70);
        rdc(OFS_IO_CTL, 32'h88);
        rdc(OFS_COUNTER, 32'h0);
        rdc(OFS_RUN, 32'h0);
        for (int k = 0; k < 4; k++)
            rdc(OFS_GR_BASE + 6'(4 * k), 32'hffff);
        bus(1'b1, OFS_IRQ_EN, 32'hff, 4'he);
        rdc(OFS_IRQ_EN, 32'h70);
        bus(1'b1, 6'h24, 32'hff, 4'hf);
        rdc(6'h24, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            r = $urandom;
            wrr(OFS_IRQ_EN, r);
            rdc(OFS_IRQ_EN, {24'h0, r[7:0] & 8'h8f | 8'h70});
            wrr(OFS_IO_CTL, r);
            rdc(OFS_IO_CTL, {24'h0, r[7:0] & 8'h77 | 8'h88});
        end
        $display("register test done");
        for (int k = 0; k < 24; k++)
        begin
            ch = k < 16 ? k / 4 : $urandom % 4;
            act = k < 16 ? 2'(k) : 2'($urandom);
            g = 16 + $urandom % 32'hfe00;
            r = $urandom;
            wrr(OFS_IO_CTL, {26'h0, act, 2'b00, act});
            wrr(OFS_IRQ_EN, r);
            wrr(OFS_GR_BASE + 6'(4 * ch), g);
            spin(16'(g - 3));
            chk(rq[ch], 1'b1);
            chk(irq[ch], r[ch]);
            if (ch < 2)
            begin
                pexp[ch] = exp_pin(pexp[ch], act);
                chk(pin_o[ch], pexp[ch]);
            end
            clr(ch);
            chk(irq[ch], 1'b0);
            wrr(OFS_GR_BASE + 6'(4 * ch), 32'hffff);
        end
        wrr(OFS_IO_CTL, 32'h0);
        wrr(OFS_IRQ_EN, 32'h80);
        spin(16'hfffd);
        chk(rq[7], 1'b1);
        chk(wrap_irq, 1'b1);
        clr(7);
        chk(wrap_irq, 1'b0);
        $display("compare and wrap test done");
        for (int k = 0; k < 8; k++)
        begin
            ch = k / 4;
            act = 2'(k);
            dly <= 4'($urandom % 4);
            wrr(OFS_IO_CTL, (32'h4 | act) << (4 * ch));
            for (int e = 1; e >= 0; e--)
            begin
                g = $urandom % 32'hff00;
                wrr(OFS_COUNTER, g);
                rdc(OFS_COUNTER, g);
                bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
                wrr(OFS_STATUS, 32'h0);
                lvl[ch] <= e[0];
                repeat (8) @(posedge clock_i);
                bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
                chk(rq[ch], exp_cap(act, e[0]));
                if (exp_cap(act, e[0]))
                    rdc(OFS_GR_BASE + 6'(4 * ch), g);
            end
        end
        $display("capture test done");
        tally_and_finish();
    end
endmodule
